// *** hw/bpb_pkg.sv ***
// Package: register map, field layout and bus carrier types of the port bank
package bpb_pkg;
	// ==========================================================
	// Register map (printed offsets not all multiples of four: index * 4)
	localparam logic [11:0] IDX_GROUP0_DATA = 12'hf60;
	localparam logic [11:0] IDX_GROUP1_DATA = 12'hf61;
	localparam logic [11:0] IDX_GROUP2_DATA = 12'hf62;
	localparam logic [11:0] IDX_GROUP3_DATA = 12'hf63;
	localparam logic [11:0] IDX_DIR_CTRL    = 12'hf7d;
	localparam logic [11:0] IDX_PULLUP_CTRL = 12'hf7e;
	localparam int          ADDR_W          = 14;
	localparam int          GROUPS          = 4;
	localparam int          GROUP_W         = 4;
	localparam int          PINS            = 16;
	localparam logic [3:0]  DIR_RESET       = 4'h0;
	localparam logic [3:0]  PULLUP_RESET    = 4'h0;

	// ==========================================================
	// APB carriers
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} bpb_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} bpb_apb_rsp_t;

	// Pin carrier: output, output enable, pull-up enable per pin
	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe;
		logic [15:0] pull;
	} bpb_pin_drv_t;
endpackage

// *** hw/bpb_port_bank.sv ***
// Sixteen-pin bidirectional port bank with APB register access
// Summary of operation
// - Sixteen pins in four groups of four
// - Push-pull or open-drain chosen at build time
// - Group 3 pins may be output-only
// - Direction bit 0 puts group in input
// - Direction bit 1 drives stored data
// - Output-only pins ignore direction bit
// - Direction register, one bit per group
// - Direction bits clear to input at reset
// - Pull-up register, zero enables pull-ups
// - Pull-up bits clear to zero at reset
// - Four data registers store written pin values
// - Data writes accepted in input mode
// - Output-only pins drive written data directly
// - Data reads return actual pin levels
// - Undriven open-drain high without pull reads unknown (output-only pins with pull-up bit zero read the pin level instead)
// - Output-only pins never get pull-ups
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module bpb_port_bank
	import bpb_pkg::*;
#(
	parameter logic [1:0]  OD_GROUP01 = 2'b00,     // Bit g: group g open-drain
	parameter logic [7:0]  OD_PIN23   = 8'h00,     // Bit: pin of groups 2,3 open-drain
	parameter logic [3:0]  OUT_ONLY3  = 4'h0       // Bit: group 3 pin output-only
) (
	// Clock and reset
	input  wire logic          CLK_I,
	input  wire logic          SYS_RST_I,
	// APB slave
	input  wire bpb_pkg::bpb_apb_req_t APB_REQ_I,
	output      bpb_pkg::bpb_apb_rsp_t APB_RSP_O,
	// Port pins
	input  wire logic [15:0]   PIN_I,
	output      logic [15:0]   PIN_O,
	output      logic [15:0]   PIN_OE_O,
	output      logic [15:0]   PIN_PULL_O
);
	import bpb_pkg::*;

	// ==========================================================
	// Build-time pin options
	logic [15:0] open_drain;
	logic [15:0] out_only;
	assign open_drain = {OD_PIN23, {4{OD_GROUP01[1]}}, {4{OD_GROUP01[0]}}};
	assign out_only   = {OUT_ONLY3, 12'h000};

	// ==========================================================
	// Registers
	logic [3:0]  dir_ctrl;
	logic [3:0]  pullup_ctrl;
	logic [15:0] port_data;
	logic [15:0] pin_meta;
	logic [15:0] pin_sync;

	logic [11:0] idx;
	logic        wr_take;
	logic        rd_take;
	assign idx     = APB_REQ_I.paddr[ADDR_W-1:2];
	assign wr_take = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite & APB_RSP_O.pready;
	assign rd_take = APB_REQ_I.psel & ~APB_REQ_I.penable & ~APB_REQ_I.pwrite;

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			dir_ctrl <= DIR_RESET;
		end else if (wr_take && idx == IDX_DIR_CTRL) begin
			dir_ctrl <= APB_REQ_I.pwdata[3:0];
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pullup_ctrl <= PULLUP_RESET;
		end else if (wr_take && idx == IDX_PULLUP_CTRL) begin
			pullup_ctrl <= APB_REQ_I.pwdata[3:0];
		end
	end

	// No reset on port data: contents stay unknown until written
	always_ff @(posedge CLK_I) begin
		if (wr_take) begin
			case (idx)
				IDX_GROUP0_DATA: port_data[3:0]   <= APB_REQ_I.pwdata[3:0];
				IDX_GROUP1_DATA: port_data[7:4]   <= APB_REQ_I.pwdata[3:0];
				IDX_GROUP2_DATA: port_data[11:8]  <= APB_REQ_I.pwdata[3:0];
				IDX_GROUP3_DATA: port_data[15:12] <= APB_REQ_I.pwdata[3:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Pin input synchroniser
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pin_meta <= 16'h0000;
			pin_sync <= 16'h0000;
		end else begin
			pin_meta <= PIN_I;
			pin_sync <= pin_meta;
		end
	end

	// ==========================================================
	// Pin drive, one slice per pin
	logic [15:0] next_out;
	logic [15:0] next_oe;
	logic [15:0] next_pull;
	logic [15:0] rd_level;
	genvar p;
	generate
		for (p = 0; p < PINS; p++) begin : g_pin
			logic drive_mode;
			assign drive_mode = out_only[p] | dir_ctrl[p/GROUP_W];
			// Open-drain only pulls low; a one releases the pin
			assign next_out[p] = open_drain[p] ? 1'b0 : port_data[p];
			assign next_oe[p]  = drive_mode & (~open_drain[p] | ~port_data[p]);
			assign next_pull[p] = ~pullup_ctrl[p/GROUP_W] & ~out_only[p];
			// Read back the pin; unknown when a released open-drain pin in drive mode has its group pull-up bit at one
			assign rd_level[p] = (drive_mode & open_drain[p] & port_data[p]
			                      & pullup_ctrl[p/GROUP_W]) ? 1'bx : pin_sync[p];
		end
	endgenerate

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			PIN_O      <= 16'h0000;
			PIN_OE_O   <= 16'h0000;
			PIN_PULL_O <= 16'h0000;
		end else begin
			PIN_O      <= next_out;
			PIN_OE_O   <= next_oe;
			PIN_PULL_O <= next_pull;
		end
	end

	// ==========================================================
	// APB response: no wait states, read data captured in setup
	logic [31:0] next_rdata;
	logic        next_err;
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		case (idx)
			IDX_GROUP0_DATA: next_rdata[3:0] = rd_level[3:0];
			IDX_GROUP1_DATA: next_rdata[3:0] = rd_level[7:4];
			IDX_GROUP2_DATA: next_rdata[3:0] = rd_level[11:8];
			IDX_GROUP3_DATA: next_rdata[3:0] = rd_level[15:12];
			IDX_DIR_CTRL:    next_rdata[3:0] = dir_ctrl;
			IDX_PULLUP_CTRL: next_rdata[3:0] = pullup_ctrl;
			default:         next_err = 1'b1;
		endcase
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			APB_RSP_O <= '0;
		end else begin
			APB_RSP_O.pready <= APB_REQ_I.psel & ~APB_REQ_I.penable;
			APB_RSP_O.pslverr <= APB_REQ_I.psel & ~APB_REQ_I.penable & next_err;
			if (rd_take) begin
				APB_RSP_O.prdata <= next_rdata;
			end
		end
	end

	// ==========================================================
	// Checks
	a_input_no_drive: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		$past(dir_ctrl[0] == 1'b0) && !$past(SYS_RST_I) |-> PIN_OE_O[3:0] == 4'h0)
		else $error("group 0 drives in input mode");
	a_output_drive: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		$past(dir_ctrl[0] && !open_drain[0]) && !$past(SYS_RST_I)
		|-> PIN_OE_O[0] && PIN_O[0] == $past(port_data[0]))
		else $error("group 0 output mismatch");
	a_dir_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		wr_take && idx == IDX_DIR_CTRL |=> dir_ctrl == $past(APB_REQ_I.pwdata[3:0]))
		else $error("direction write lost");
	a_pull_write: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		wr_take && idx == IDX_PULLUP_CTRL |=> pullup_ctrl == $past(APB_REQ_I.pwdata[3:0]))
		else $error("pull-up write lost");
	a_pull_out: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		!$past(SYS_RST_I) |-> PIN_PULL_O[3:0] == {4{~$past(pullup_ctrl[0])}})
		else $error("pull-up output mismatch");
	a_outonly_pull: assert property (@(posedge CLK_I)
		(PIN_PULL_O & out_only) == 16'h0000)
		else $error("pull-up on output-only pin");
	a_od_high: assert property (@(posedge CLK_I)
		(PIN_O & open_drain) == 16'h0000)
		else $error("open-drain pin driven high");
	a_data_store: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		wr_take && idx == IDX_GROUP2_DATA |=> port_data[11:8] == $past(APB_REQ_I.pwdata[3:0]))
		else $error("data write lost");
	a_ready_once: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		APB_REQ_I.psel && !APB_REQ_I.penable |=> APB_RSP_O.pready)
		else $error("no ready after setup");
	c_dir_write:  cover property (@(posedge CLK_I) wr_take && idx == IDX_DIR_CTRL);
	c_data_read:  cover property (@(posedge CLK_I) rd_take && idx == IDX_GROUP0_DATA);
	c_bad_addr:   cover property (@(posedge CLK_I) APB_RSP_O.pslverr);
	c_group3_out: cover property (@(posedge CLK_I) PIN_OE_O[15:12] != 4'h0);
endmodule

// *** tb/bpb_pin_model.sv ***
// Pin-side model: resolves each wire from device drive, pull-up and external load
`timescale 1ns/1ps
module bpb_pin_model (
	// Control
	input  wire logic        clk_i,
	// Device side
	input  wire logic [15:0] out_i,
	input  wire logic [15:0] oe_i,
	input  wire logic [15:0] pull_i,
	// External load
	input  wire logic [15:0] ext_i,
	input  wire logic [15:0] ext_en_i,
	// Wire level
	output      logic [15:0] pin_o
);
	// Floating lines toggle so no stale level can pass for a real one
	logic [15:0] flt = 16'h0000;
	always @(posedge clk_i) flt <= ~flt;
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pin_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_i[i] : pull_i[i] ? 1'b1 : flt[i];
		end
	end
endmodule

// *** tb/tb.sv ***
// Testbench: APB register tests of the port bank against the pin model
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module tb;
	import bpb_pkg::*;
	// ==========================================
	// Stimulus and wiring
	logic CLK_I = 1'b0;
	logic SYS_RST_I = 1'b1;
	bpb_apb_req_t req = '0;
	bpb_apb_rsp_t rsp;
	logic [15:0] pin_i, pin_o, pin_oe, pin_pull;
	logic [15:0] ext = 16'h0000;
	logic [15:0] ext_en = 16'h0000;
	logic [31:0] rd;
	logic err;
	int n_fail = 0;
	int total_checks = 0;
	always #10 CLK_I = ~CLK_I;
	// Group 1 open-drain, pin 15 output-only
	bpb_port_bank #(.OD_GROUP01(2'b10), .OD_PIN23(8'h00), .OUT_ONLY3(4'h8)) dut (
		.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .APB_REQ_I(req), .APB_RSP_O(rsp),
		.PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe), .PIN_PULL_O(pin_pull));
	bpb_pin_model u_pins (.clk_i(CLK_I), .out_i(pin_o), .oe_i(pin_oe), .pull_i(pin_pull),
		.ext_i(ext), .ext_en_i(ext_en), .pin_o(pin_i));
	// ==========================================
	// Bus access
	task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge CLK_I);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: wd};
		@(posedge CLK_I);
		req.penable <= 1'b1;
		do begin
			@(posedge CLK_I);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("Error %0t: no ready from slave", $time);
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		// Pins follow one cycle late, input path adds two flops
		repeat (4) @(posedge CLK_I);
	endtask
	task automatic final_report();
		$display("Checks %0d, failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (10) @(posedge CLK_I);
		SYS_RST_I <= 1'b0;
		repeat (2) @(posedge CLK_I);
		`CHK(pin_pull, 16'h7fff)
		`CHK(pin_oe, 16'h8000)
		apb(1'b0, IDX_DIR_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, IDX_PULLUP_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		ext <= 16'h000a;
		ext_en <= 16'h000f;
		apb(1'b1, IDX_GROUP0_DATA, 32'h5);
		apb(1'b0, IDX_GROUP0_DATA, 32'h0);
		`CHK(rd, 32'ha)
		`CHK(pin_oe[3:0], 4'h0)
		ext_en <= 16'h0000;
		apb(1'b1, IDX_GROUP3_DATA, 32'h8);
		`CHK(pin_o[15], 1'b1)
		apb(1'b1, IDX_DIR_CTRL, 32'hf);
		apb(1'b0, IDX_GROUP0_DATA, 32'h0);
		`CHK(rd, 32'h5)
		apb(1'b1, IDX_GROUP2_DATA, 32'hc);
		apb(1'b0, IDX_GROUP2_DATA, 32'h0);
		`CHK(rd, 32'hc)
		apb(1'b1, IDX_GROUP1_DATA, 32'h6);
		`CHK(pin_oe[7:4], 4'h9)
		apb(1'b0, IDX_GROUP1_DATA, 32'h0);
		`CHK(rd, 32'h6)
		apb(1'b1, IDX_PULLUP_CTRL, 32'h5);
		apb(1'b0, IDX_PULLUP_CTRL, 32'h0);
		`CHK(rd, 32'h5)
		`CHK(pin_pull, 16'h70f0)
		apb(1'b1, IDX_DIR_CTRL, 32'h0);
		`CHK(pin_oe, 16'h8000)
		apb(1'b0, 12'h123, 32'h0);
		`CHK({err, rd}, 33'h100000000)
		final_report();
	end
	initial begin
		repeat (3000) @(posedge CLK_I);
		n_fail++;
		final_report();
	end
endmodule
